// ---- shared/lsscfg_defines.vh ----
/*
 holds the constants of the layer-setting slave command handler:
 command specifiers, frame identifiers, defaults and table indices.
 assumes inclusion by bare name from the core files.
*/
// Notes on behaviour
// [RQ1] product-code selection frame: specifier 47h, code bytes 1-4, rest zero
// [RQ2] revision low bound frame: specifier 48h, bound bytes 1-4, rest zero
// [RQ3] revision high bound frame: specifier 49h, bound bytes 1-4, rest zero
// [RQ4] selected only when own revision lies within received bounds
// [RQ5] serial low bound frame: specifier 4Ah, bound bytes 1-4, rest zero
// [RQ6] serial high bound 4Bh; serial within bounds selects the slave
// [RQ7] full match answers 4Fh with bytes 1-7 zero
// [RQ8] as delivered node identifier 7Fh and 1000 kBd
// [RQ9] requests on 7E5, answers on 7E4; inquiry 5Eh answers node id
// [RQ10] switch state 04h: byte1 01h configuration, 00h waiting, no answer
// [RQ11] configure node id 11h, confirm 11h with error 00h when accepted
// [RQ12] bit timing 13h, selector 00h, index byte 2; confirm 13h error 00h
// [RQ13] store 17h saves pending id and rate, confirm 17h error 00h
// [RQ14] stored values act after restart; boot frame 00h on 700h plus id
// [RQ15] no answer to identify requests unless every criterion matched
// [RQ16] vendor selection frame: specifier 46h, vendor bytes 1-4, rest zero
// [RQ17] mode byte 00h waiting, 01h configuration, bytes 2-7 zero
// [RQ18] index map 0,2,3,4,6,7,8 supported; other index error 01h
`ifndef LSSCFG_DEFINES_VH
`define LSSCFG_DEFINES_VH
////////////////////////////////////////////////////////////////////////////////
`define LSSCFG_ID_REQ      11'h7e5
`define LSSCFG_ID_RSP      11'h7e4
`define LSSCFG_ID_BOOT     11'h700
`define LSSCFG_CS_SWITCH   8'h04
`define LSSCFG_CS_SETID    8'h11
`define LSSCFG_CS_SETBIT   8'h13
`define LSSCFG_CS_STORE    8'h17
`define LSSCFG_CS_VENDOR   8'h46
`define LSSCFG_CS_PROD     8'h47
`define LSSCFG_CS_REVLO    8'h48
`define LSSCFG_CS_REVHI    8'h49
`define LSSCFG_CS_SERLO    8'h4a
`define LSSCFG_CS_SERHI    8'h4b
`define LSSCFG_CS_IDENT    8'h4f
`define LSSCFG_CS_INQID    8'h5e
`define LSSCFG_MODE_WAIT   8'h00
`define LSSCFG_MODE_CONF   8'h01
`define LSSCFG_ERR_OK      8'h00
`define LSSCFG_ERR_BAD     8'h01
`define LSSCFG_ERR_NVM     8'h02
`define LSSCFG_DEF_NODE    7'h7f
`define LSSCFG_DEF_INDEX   4'h0
`define LSSCFG_TBL_SEL     8'h00
`endif

// ---- core/lsscfg_match.v ----
/*
 identify-remote-slave criteria latch and address compare.
 assumes frames are decoded by the parent and given one cycle strobes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lsscfg_defines.vh"
module lsscfg_match #(
	parameter [31:0] VENDOR_ID = 32'h00000001, // arbitrary value
	parameter [31:0] PROD_CODE = 32'h00000002, // arbitrary value
	parameter [31:0] REV_NUM   = 32'h00000003, // arbitrary value
	parameter [31:0] SER_NUM   = 32'h00000004  // arbitrary value
) (
	// clock and reset
	input  wire        mclk_i,
	input  wire        rstn_i,
	// decoded selection frame
	input  wire        sel_v_i,
	input  wire [7:0]  sel_cs_i,
	input  wire [31:0] sel_val_i,
	// result
	output reg         hit_o
);
	reg [3:0] ok_q;  // vendor, product, revision, serial
	reg       rlo_q;
	reg       slo_q;
	////////////////////////////////////////////////////////////////////////
	// criteria flags; a new vendor frame clears ok_q[3:1] and reloads ok_q[0], not rlo_q or slo_q
	always @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ok_q  <= 4'h0;
			rlo_q <= 1'b0;
			slo_q <= 1'b0;
			hit_o <= 1'b0;
		end else begin
			hit_o <= 1'b0;
			if (sel_v_i) begin
				case (sel_cs_i)
				`LSSCFG_CS_VENDOR: begin
					ok_q <= {3'h0, sel_val_i == VENDOR_ID}; // RQ16
				end
				`LSSCFG_CS_PROD: begin
					ok_q[1] <= (sel_val_i == PROD_CODE); // RQ1
				end
				`LSSCFG_CS_REVLO: begin
					rlo_q <= (REV_NUM >= sel_val_i); // RQ2
				end
				`LSSCFG_CS_REVHI: begin
					ok_q[2] <= rlo_q && (REV_NUM <= sel_val_i); // RQ3 RQ4
				end
				`LSSCFG_CS_SERLO: begin
					slo_q <= (SER_NUM >= sel_val_i); // RQ5
				end
				`LSSCFG_CS_SERHI: begin
					// last criterion closes the sequence
					hit_o <= (&ok_q[2:0]) && slo_q &&
						(SER_NUM <= sel_val_i); // RQ6 RQ15
					ok_q[3] <= slo_q && (SER_NUM <= sel_val_i);
				end
				default: begin
					ok_q <= ok_q;
				end
				endcase
			end
		end
	end
endmodule // lsscfg_match
`default_nettype wire

// ---- core/lsscfg_slave.v ----
/*
 layer-setting slave command handler: decodes request frames, answers
 with response frames, holds pending and stored node id and bit rate.
 assumes one received frame per rx strobe and a transmitter that takes
 a frame whenever tx_ready_i is high while tx_valid_o stands.
 stored values are sampled once, on the first edge after reset; requests
 are taken from the second edge on, one at a time, once tx has drained; state switch and selection frames are taken without a free tx.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lsscfg_defines.vh"
module lsscfg_slave #(
	parameter [31:0] VENDOR_ID = 32'h00000001, // arbitrary value
	parameter [31:0] PROD_CODE = 32'h00000002, // arbitrary value
	parameter [31:0] REV_NUM   = 32'h00000003, // arbitrary value
	parameter [31:0] SER_NUM   = 32'h00000004  // arbitrary value
) (
	// clock and reset
	input  wire        mclk_i,
	input  wire        rstn_i,
	// received frame
	input  wire        rx_valid_i,
	input  wire [10:0] rx_id_i,
	input  wire [63:0] rx_data_i,
	// transmitted frame
	output reg         tx_valid_o,
	output reg  [10:0] tx_id_o,
	output reg  [3:0]  tx_len_o,
	output reg  [63:0] tx_data_o,
	input  wire        tx_ready_i,
	// nonvolatile store handshake
	output reg         nv_write_o,
	output reg  [6:0]  nv_node_o,
	output reg  [3:0]  nv_index_o,
	input  wire        nv_fail_i,
	// stored values, read at restart
	input  wire [6:0]  nv_node_i,
	input  wire [3:0]  nv_index_i,
	input  wire        nv_valid_i,
	// active settings
	output reg  [6:0]  node_identifier_o,
	output reg  [3:0]  bit_index_o,
	output reg         conf_mode_o
);
	////////////////////////////////////////////////////////////////////////
	// one-hot states: boot frame, normal run, store in flight
	localparam ST_BOOT = 3'b001;
	localparam ST_RUN  = 3'b010;
	localparam ST_BUSY = 3'b100;

	// pending settings wait for a store and a restart to act
	reg [2:0]  st_q;
	reg [6:0]  pend_node_q;
	reg [3:0]  pend_index_q;
	wire       hit;
	// request fields: specifier, first and second data byte
	wire [7:0] cs = rx_data_i[7:0];
	wire [7:0] b1 = rx_data_i[15:8];
	wire [7:0] b2 = rx_data_i[23:16];
	// only frames on the request identifier count
	wire       req = rx_valid_i && (rx_id_i == `LSSCFG_ID_REQ); // RQ9
	wire       sel = req && cs >= `LSSCFG_CS_VENDOR &&
	                 cs <= `LSSCFG_CS_SERHI;

	// supported bit-timing table indices
	function idx_ok;
		input [7:0] i;
		begin
			case (i)
			8'h00, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08:
				idx_ok = 1'b1; // RQ18
			default: idx_ok = 1'b0;
			endcase
		end
	endfunction

	// response frame with specifier and one data byte
	function [63:0] rsp;
		input [7:0] c;
		input [7:0] d;
		begin
			rsp = {48'h0, d, c};
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// identification criteria
	// the last range frame closes the selection
	lsscfg_match #(
		.VENDOR_ID (VENDOR_ID),
		.PROD_CODE (PROD_CODE),
		.REV_NUM   (REV_NUM),
		.SER_NUM   (SER_NUM)
	) u_match (
		.mclk_i    (mclk_i),
		.rstn_i    (rstn_i),
		.sel_v_i   (sel),
		.sel_cs_i  (cs),
		.sel_val_i (rx_data_i[39:8]),
		.hit_o     (hit)
	);

	////////////////////////////////////////////////////////////////////////
	// command decode and response
	always @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q              <= ST_BOOT;
			tx_valid_o        <= 1'b0;
			tx_id_o           <= 11'h000;
			tx_len_o          <= 4'h0;
			tx_data_o         <= 64'h0;
			nv_write_o        <= 1'b0;
			nv_node_o         <= `LSSCFG_DEF_NODE;
			nv_index_o        <= `LSSCFG_DEF_INDEX;
			node_identifier_o <= `LSSCFG_DEF_NODE;  // RQ8
			bit_index_o       <= `LSSCFG_DEF_INDEX; // RQ8
			conf_mode_o       <= 1'b0;
			pend_node_q       <= `LSSCFG_DEF_NODE;
			pend_index_q      <= `LSSCFG_DEF_INDEX;
		end else begin
			// store strobe lasts one cycle
			nv_write_o <= 1'b0;
			if (tx_valid_o && tx_ready_i)
				tx_valid_o <= 1'b0;
			case (st_q)
			ST_BOOT: begin
				// stored values take effect only here, after restart
				if (nv_valid_i && nv_node_i != 7'h00) begin
					node_identifier_o <= nv_node_i; // RQ14
					bit_index_o       <= nv_index_i;
					pend_node_q       <= nv_node_i;
					pend_index_q      <= nv_index_i;
					tx_id_o <= `LSSCFG_ID_BOOT + {4'h0, nv_node_i}; // RQ14
				end else begin
					tx_id_o <= `LSSCFG_ID_BOOT +
						{4'h0, `LSSCFG_DEF_NODE};
				end
				// boot frame: one zero byte
				tx_len_o   <= 4'h1;
				tx_data_o  <= 64'h0; // RQ14
				tx_valid_o <= 1'b1;
				st_q       <= ST_RUN;
			end
			ST_BUSY: begin
				// store result turns into confirmation
				tx_id_o    <= `LSSCFG_ID_RSP;
				tx_len_o   <= 4'h8;
				tx_data_o  <= rsp(`LSSCFG_CS_STORE, nv_fail_i ?
					`LSSCFG_ERR_NVM : `LSSCFG_ERR_OK); // RQ13
				tx_valid_o <= 1'b1;
				st_q       <= ST_RUN;
			end
			ST_RUN: begin
				// identify answer, in any mode
				if (hit && !tx_valid_o) begin
					tx_id_o    <= `LSSCFG_ID_RSP;
					tx_len_o   <= 4'h8;
					tx_data_o  <= rsp(`LSSCFG_CS_IDENT, 8'h00); // RQ7
					tx_valid_o <= 1'b1;
				end else if (req && cs == `LSSCFG_CS_SWITCH) begin
					// no confirmation for the state switch
					if (b1 == `LSSCFG_MODE_CONF)
						conf_mode_o <= 1'b1; // RQ10 RQ17
					else if (b1 == `LSSCFG_MODE_WAIT)
						conf_mode_o <= 1'b0; // RQ10 RQ17
				end else if (req && conf_mode_o && !tx_valid_o) begin
					// needs conf mode and a free tx
					tx_id_o  <= `LSSCFG_ID_RSP;
					tx_len_o <= 4'h8;
					case (cs)
					`LSSCFG_CS_INQID: begin
						tx_data_o  <= rsp(`LSSCFG_CS_INQID,
							{1'b0, node_identifier_o}); // RQ9
						tx_valid_o <= 1'b1;
					end
					`LSSCFG_CS_SETID: begin
						// ids 01h to 7fh only
						if (b1 >= 8'h01 && b1 <= 8'h7f) begin
							pend_node_q <= b1[6:0];
							tx_data_o   <= rsp(`LSSCFG_CS_SETID,
								`LSSCFG_ERR_OK); // RQ11
						end else begin
							tx_data_o <= rsp(`LSSCFG_CS_SETID,
								`LSSCFG_ERR_BAD);
						end
						tx_valid_o <= 1'b1;
					end
					`LSSCFG_CS_SETBIT: begin
						// standard table, known index
						if (b1 == `LSSCFG_TBL_SEL && idx_ok(b2)) begin
							pend_index_q <= b2[3:0]; // RQ12
							tx_data_o    <= rsp(`LSSCFG_CS_SETBIT,
								`LSSCFG_ERR_OK); // RQ12
						end else begin
							tx_data_o <= rsp(`LSSCFG_CS_SETBIT,
								`LSSCFG_ERR_BAD); // RQ18
						end
						tx_valid_o <= 1'b1;
					end
					`LSSCFG_CS_STORE: begin
						// answer on the next cycle, with nv_fail_i as the result
						nv_write_o <= 1'b1; // RQ13
						nv_node_o  <= pend_node_q;
						nv_index_o <= pend_index_q;
						st_q       <= ST_BUSY;
					end
					default: begin
						// unknown specifier: ignored
						st_q <= ST_RUN;
					end
					endcase
				end
			end
			default: begin
				// illegal state: back to run
				st_q <= ST_RUN;
			end
			endcase
		end
	end
endmodule // lsscfg_slave
`default_nettype wire

// ---- testbench/lsscfg_chk_checker.sv ----
/* assertions on the slave handler ports
 bound onto lsscfg_slave, one clock domain */
`timescale 1ns/1ps
`default_nettype none
module lsscfg_chk (
	// clock and reset
	input wire logic        mclk_i,
	input wire logic        rstn_i,
	// frames
	input wire logic        rx_valid_i,
	input wire logic [10:0] rx_id_i,
	input wire logic [63:0] rx_data_i,
	input wire logic        tx_valid_o,
	input wire logic        tx_ready_i,
	input wire logic [10:0] tx_id_o,
	input wire logic [3:0]  tx_len_o,
	input wire logic [63:0] tx_data_o,
	// settings
	input wire logic        nv_write_o,
	input wire logic [6:0]  node_identifier_o,
	input wire logic [3:0]  bit_index_o,
	input wire logic        conf_mode_o
);
	// request that the slave takes, and its specifier
	wire rq = rx_valid_i && rx_id_i == 11'h7e5 && !tx_valid_o;
	wire [7:0] cs = rx_data_i[7:0];
	// low byte of the outgoing frame
	wire [7:0] cs_o = tx_data_o[7:0];
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
////////////////
	a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=>
		tx_valid_o && $stable(tx_data_o) && $stable(tx_id_o))
		else $error("frame changed before taken");
	a_inq_node: assert property (rq && conf_mode_o && cs == 8'h5e |=>
		tx_id_o == 11'h7e4 &&
		tx_data_o[15:0] == {1'b0, node_identifier_o, 8'h5e})
		else $error("bad inquiry answer");
	a_go_conf: assert property (rq && cs == 8'h04 &&
		rx_data_i[15:8] == 8'h01 |=> conf_mode_o && !tx_valid_o)
		else $error("no configuration mode");
	a_go_wait: assert property (rq && cs == 8'h04 &&
		rx_data_i[15:8] == 8'h00 |=> !conf_mode_o && !tx_valid_o)
		else $error("no waiting mode");
	a_store_seq: assert property (rq && conf_mode_o && cs == 8'h17 |=>
		nv_write_o ##1 tx_valid_o && tx_data_o[7:0] == 8'h17)
		else $error("store sequence wrong");
	a_ident_zero: assert property (tx_valid_o && cs_o == 8'h4f |->
		tx_data_o[63:8] == 56'h0 && tx_id_o == 11'h7e4)
		else $error("identify frame not clean");
	a_id_ok: assert property (rq && conf_mode_o && cs == 8'h11 &&
		rx_data_i[15:8] inside {[8'h01:8'h7f]} |=>
		tx_data_o[15:0] == 16'h0011)
		else $error("node id not confirmed");
	a_rate_code: assert property (rq && conf_mode_o &&
		cs == 8'h13 |=> tx_data_o[15:0] ==
		(($past(rx_data_i[15:8]) == 8'h00 && $past(rx_data_i[23:16])
		inside {8'h00, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08}) ?
		16'h0013 : 16'h0113))
		else $error("bit timing answer wrong");
	a_boot_frame: assert property ($past(rstn_i) && !$past(rstn_i, 2) |->
		tx_valid_o && tx_len_o == 4'h1 && tx_data_o[7:0] == 8'h00 &&
		tx_id_o == 11'h700 + {4'h0, node_identifier_o})
		else $error("boot frame wrong");
	a_node_hold: assert property ($past(rstn_i, 2) |->
		$stable(node_identifier_o) && $stable(bit_index_o))
		else $error("active setting changed");
endmodule // lsscfg_chk
bind lsscfg_slave lsscfg_chk i_chk (
	.mclk_i            (mclk_i),
	.rstn_i            (rstn_i),
	.rx_valid_i        (rx_valid_i),
	.rx_id_i           (rx_id_i),
	.rx_data_i         (rx_data_i),
	.tx_valid_o        (tx_valid_o),
	.tx_ready_i        (tx_ready_i),
	.tx_id_o           (tx_id_o),
	.tx_len_o          (tx_len_o),
	.tx_data_o         (tx_data_o),
	.nv_write_o        (nv_write_o),
	.node_identifier_o (node_identifier_o),
	.bit_index_o       (bit_index_o),
	.conf_mode_o       (conf_mode_o)
);
`default_nettype wire

// ---- testbench/lsscfg_far.sv ----
/* far side model: frame taker and nonvolatile store
 assumes the slave tx and store handshakes */
`timescale 1ns/1ps
`default_nettype none
module lsscfg_far (
	// clock and modes
	input wire logic       mclk_i,
	input wire logic       slow_i,
	input wire logic       fail_i,
	// from the slave
	input wire logic       valid_i,
	input wire logic       wr_i,
	input wire logic [6:0] wnode_i,
	input wire logic [3:0] windex_i,
	// to the slave
	output logic           ready_o,
	output logic           fail_o,
	output logic [6:0]     node_o,
	output logic [3:0]     index_o,
	output logic           stored_o
);
	logic [1:0] wait_q;
	// empty store at power up, kept across slave resets
	initial begin
		{ready_o, fail_o, node_o, index_o, stored_o} = 14'h0;
		wait_q = 2'h0;
	end
////////////////
	// take a frame at once, or after a stall when slow
	always @(posedge mclk_i) begin
		wait_q <= valid_i && !ready_o ? wait_q + 2'h1 : 2'h0;
		ready_o <= valid_i && !ready_o && (!slow_i || wait_q == 2'h2);
	end
	// a refused write leaves the old copy
	always @(posedge mclk_i) begin
		fail_o <= fail_i;
		if (wr_i && !fail_i) begin
			node_o <= wnode_i;
			index_o <= windex_i;
			stored_o <= 1'b1;
		end
	end
endmodule // lsscfg_far
`default_nettype wire

// ---- testbench/testbench.sv ----
/* bench for the slave handler: frame table, then rate, refusal,
 identify and restart cases; assumes the far model and checker */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic mclk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic rx_valid_i = 1'b0;
	logic [10:0] rx_id_i = 11'h7e5;
	logic [63:0] rx_data_i = 64'h0;
	logic slow = 1'b0;
	logic fail = 1'b0;
	wire tx_valid_o, tx_ready_i, nv_write_o, nv_fail_i, nv_valid_i;
	wire conf_mode_o;
	wire [10:0] tx_id_o;
	wire [3:0] tx_len_o, nv_index_o, nv_index_i, bit_index_o;
	wire [63:0] tx_data_o;
	wire [6:0] nv_node_o, nv_node_i, node_identifier_o;
	int err_total = 0;
	int total_checks = 0;
	logic [10:0] cid;
	logic [15:0] cd;
	logic [79:0] rows [0:8];
	lsscfg_slave #(.VENDOR_ID(32'h5a), .PROD_CODE(32'h6b), .REV_NUM(32'h20),
		.SER_NUM(32'h40)) i_dut (
		.mclk_i            (mclk_i),
		.rstn_i            (rstn_i),
		.rx_valid_i        (rx_valid_i),
		.rx_id_i           (rx_id_i),
		.rx_data_i         (rx_data_i),
		.tx_valid_o        (tx_valid_o),
		.tx_id_o           (tx_id_o),
		.tx_len_o          (tx_len_o),
		.tx_data_o         (tx_data_o),
		.tx_ready_i        (tx_ready_i),
		.nv_write_o        (nv_write_o),
		.nv_node_o         (nv_node_o),
		.nv_index_o        (nv_index_o),
		.nv_fail_i         (nv_fail_i),
		.nv_node_i         (nv_node_i),
		.nv_index_i        (nv_index_i),
		.nv_valid_i        (nv_valid_i),
		.node_identifier_o (node_identifier_o),
		.bit_index_o       (bit_index_o),
		.conf_mode_o       (conf_mode_o)
	);
	lsscfg_far i_far (.mclk_i(mclk_i), .slow_i(slow), .fail_i(fail),
		.valid_i(tx_valid_o), .wr_i(nv_write_o), .wnode_i(nv_node_o),
		.windex_i(nv_index_o), .ready_o(tx_ready_i), .fail_o(nv_fail_i),
		.node_o(nv_node_i), .index_o(nv_index_i), .stored_o(nv_valid_i));
	initial forever #4 mclk_i = ~mclk_i;
////////////////
	task automatic chk(input logic [15:0] seen, exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	// first taken frame within the bound, ffff when none
	task automatic grab;
		cd = 16'hffff;
		cid = 11'h7ff;
		repeat (12) begin
			@(posedge mclk_i);
			if (tx_valid_o && tx_ready_i && cd === 16'hffff) begin
				cd = tx_data_o[15:0];
				cid = tx_id_o;
			end
		end
	endtask
	task automatic send(input logic [63:0] d);
		@(posedge mclk_i);
		rx_valid_i <= 1'b1;
		rx_data_i <= d;
		@(posedge mclk_i);
		rx_valid_i <= 1'b0;
		grab();
	endtask
	task automatic restart;
		@(posedge mclk_i);
		rstn_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		rstn_i <= 1'b1;
		grab();
	endtask
	// full selection run; only the last frame may be answered
	task automatic ident(input logic [31:0] rl, rh, sl, sh,
		input logic [15:0] e);
		logic [31:0] v [0:5];
		v = '{32'h5a, 32'h6b, rl, rh, sl, sh};
		for (int k = 0; k < 6; k++) begin
			send({24'h0, v[k], 8'h46 + k[7:0]});
			chk(cd, k == 5 ? e : 16'hffff, "identify");
		end
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge mclk_i);
		err_total++;
		summarize();
	end
	// main sequence
	initial begin
		rows = '{{64'h0104, 16'hffff}, {64'h5e, 16'h7f5e},
			{64'h0511, 16'h0011}, {64'h0011, 16'h0111},
			{64'h040013, 16'h0013}, {64'h050013, 16'h0113},
			{64'h040113, 16'h0113},
			{64'h17, 16'h0017}, {64'h04, 16'hffff}};
		restart();
		chk({5'h0, cid}, 16'h077f, "boot id");
		foreach (rows[i]) begin
			send(rows[i][79:16]);
			chk(cd, rows[i][15:0], "row");
		end
		send(64'h0104);
		for (int i = 0; i < 10; i++) begin
			send({40'h0, i[7:0], 16'h0013});
			chk(cd, i inside {1, 5, 9} ? 16'h0113 : 16'h0013, "index");
		end
		rx_id_i <= 11'h7e4;
		send(64'h5e);
		chk(cd, 16'hffff, "foreign id");
		rx_id_i <= 11'h7e5;
		slow <= 1'b1;
		fail <= 1'b1;
		send(64'h17);
		chk(cd, 16'h0217, "store fail");
		slow <= 1'b0;
		fail <= 1'b0;
		send(64'h04);
		send(64'h5e);
		chk(cd, 16'hffff, "inquiry waiting");
		ident(32'h20, 32'h20, 32'h40, 32'h40, 16'h004f);
		ident(32'h21, 32'h30, 32'h0, 32'hff, 16'hffff);
		ident(32'h0, 32'hff, 32'h41, 32'h50, 16'hffff);
		restart();
		chk({5'h0, cid}, 16'h0705, "boot id");
		chk({9'h0, node_identifier_o}, 16'h0005, "node");
		chk({12'h0, bit_index_o}, 16'h0004, "rate");
		summarize();
	end
endmodule // testbench
`default_nettype wire
